// [hw/mdc_addr_step.sv]
// Address advance for one side of a transfer, with the optional wrap area.
// Assumes the caller holds addr stable for the cycle it uses next_addr.
`timescale 1ns/1ps
module mdc_addr_step (
    // Current address and step
    input  wire logic [31:0] addr,
    input  wire logic        inc,
    input  wire logic [1:0]  usize,
    // Wrap area
    input  wire logic        area_en,
    input  wire logic [4:0]  area_bits,
    // Result
    output logic      [31:0] next_addr,
    output logic             wrapped
);
    logic [4:0]  bits_c;
    logic [31:0] mask;
    logic [31:0] step;
    logic [31:0] sum;

    // Area is 2 bytes shifted left by area_bits, capped at 128 MB
    assign bits_c    = (area_bits > mdc_pkg::AREA_MAX) ? mdc_pkg::AREA_MAX
                                                       : area_bits;
    assign mask      = (32'h2 << bits_c) - 32'h1;
    assign step      = (usize == 2'h0) ? 32'h1 :
                       (usize == 2'h1) ? 32'h2 : 32'h4;
    assign sum       = inc ? addr + step : addr;
    assign next_addr = area_en ? ((addr & ~mask) | (sum & mask)) : sum;
    assign wrapped   = area_en && ((sum & ~mask) != (addr & ~mask));
endmodule

// [hw/mdc_dma_top.sv]
// Eight-channel DMA engine: APB registers, triggers, engine, bus master.
// Assumes the bus slave holds bm_ack low until it can finish an access,
// and peripheral requests come from logic on pclk.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Eight channels; fixed priority, channel zero highest, seven lowest.
// - Both addresses must lie in lowest or highest 256 MB.
// - Up to 1024 units per block times 65536 blocks per channel.
// - Each channel picks software, peripheral or external pin trigger.
// - Unit width per channel is 8, 16 or 32 bits.
// - Normal mode moves one unit per request; free-run never ends.
// - Repeat mode reloads the chosen start address after repeat size.
// - Block mode moves a whole block of 1 to 1024 units per request.
// - Wrap area keeps upper bits fixed; 2 bytes to 128 MB each side.
// - Transfer-end flag when the count of the mode completes.
// - Escape-end flag on repeat size done or wrap area overflow.
// - Event-link pulse per unit, or per block in block mode.
// - Software module-stop halts new work to save power.
// - Block transfer count is a 16-bit field, bits 15 to 0.
// - Monitor register shows escape-end and transfer-end flags of channels four to seven.
module mdc_dma_top (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Trigger sources
    input  wire logic [7:0]           periph_req,
    output logic      [7:0]           periph_ack,
    input  wire logic [7:0]           ext_irq_pin,
    // Bus master
    output mdc_pkg::mdc_bus_req_t     bm_out,
    input  wire logic                 bm_ack,
    input  wire logic [31:0]          bm_rdata,
    // Events
    output logic      [7:0]           tend_irq,
    output logic      [7:0]           esc_irq,
    output logic                      elc_req,
    output logic      [2:0]           elc_ch
);
    localparam int NCH = mdc_pkg::NCH;

    // ****************************************************************
    // State
    // ****************************************************************
    mdc_pkg::mdc_state_t st;
    logic [2:0]          cur_ch;
    logic [31:0]         data_reg;
    logic                module_stop;
    logic [31:0]         src       [NCH];
    logic [31:0]         dst       [NCH];
    logic [31:0]         src_start [NCH];
    logic [31:0]         dst_start [NCH];
    logic [9:0]          size_reg  [NCH];
    logic [10:0]         size_left [NCH];
    logic [15:0]         bcnt      [NCH];
    mdc_pkg::mdc_cfg_t   cfg       [NCH];
    logic [7:0]          tend, esc, err, pend, en_vec;
    logic [7:0]          ext_s1, ext_s2, ext_s3;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic        setup, acc_wr, is_glob, addr_ok, wr_sel;
    logic [2:0]  a_ch;
    logic [4:0]  a_off;
    logic [7:0]  a_oh, stat_oh, sw_pulse;
    logic [31:0] rd_mux;

    assign setup   = psel & ~penable;
    assign acc_wr  = psel & penable & pwrite;
    assign a_ch    = paddr[7:5];
    assign a_off   = paddr[4:0];
    assign is_glob = paddr[8];
    assign a_oh    = 8'h1 << a_ch;
    assign addr_ok = (paddr[31:9] == 23'h0) &&
                     (is_glob ? (paddr[8:0] == mdc_pkg::OFF_CTRL ||
                                 paddr[8:0] == mdc_pkg::OFF_SWTRIG ||
                                 paddr[8:0] == mdc_pkg::OFF_MON)
                              : (a_off <= mdc_pkg::OFF_STAT &&
                                 a_off[1:0] == 2'h0));
    assign wr_sel   = acc_wr & addr_ok & ~is_glob;
    assign stat_oh  = (wr_sel && a_off == mdc_pkg::OFF_STAT) ? a_oh : 8'h0;
    assign sw_pulse = (acc_wr && addr_ok &&
                       paddr[8:0] == mdc_pkg::OFF_SWTRIG) ? pwdata[7:0]
                                                          : 8'h0;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok;

    always_comb begin
        rd_mux = 32'h0;
        if (is_glob) begin
            unique case (paddr[8:0])
                mdc_pkg::OFF_CTRL: rd_mux = {31'h0, module_stop};
                mdc_pkg::OFF_MON:  rd_mux = {24'h0, esc[7:4], tend[7:4]};
                default:           rd_mux = 32'h0;
            endcase
        end else begin
            unique case (a_off)
                mdc_pkg::OFF_SRC:  rd_mux = src[a_ch];
                mdc_pkg::OFF_DST:  rd_mux = dst[a_ch];
                mdc_pkg::OFF_SIZE: rd_mux = {5'h0, size_left[a_ch],
                                             6'h0, size_reg[a_ch]};
                mdc_pkg::OFF_BCNT: rd_mux = {16'h0, bcnt[a_ch]};
                mdc_pkg::OFF_CFG:  rd_mux = {9'h0, cfg[a_ch]};
                mdc_pkg::OFF_STAT: rd_mux = {27'h0,
                                      (st != mdc_pkg::ST_IDLE) &&
                                      (cur_ch == a_ch),
                                      pend[a_ch], err[a_ch],
                                      esc[a_ch], tend[a_ch]};
                default:           rd_mux = 32'h0;
            endcase
        end
    end

    // Read data captured in the setup phase, so the access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= addr_ok ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_stop <= mdc_pkg::RST_STOP;
        end else if (acc_wr && addr_ok &&
                     paddr[8:0] == mdc_pkg::OFF_CTRL) begin
            module_stop <= pwdata[0];
        end
    end

    // ****************************************************************
    // Triggers
    // ****************************************************************
    logic [7:0] ext_rise, trig_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1 <= 8'h0;
            ext_s2 <= 8'h0;
            ext_s3 <= 8'h0;
        end else begin
            ext_s1 <= ext_irq_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end
    assign ext_rise = ext_s2 & ~ext_s3;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_trig
            assign en_vec[g]   = cfg[g].enable;
            assign trig_hit[g] = en_vec[g] & ~module_stop &
                (cfg[g].trig == mdc_pkg::TRIG_SW     ? sw_pulse[g] :
                 cfg[g].trig == mdc_pkg::TRIG_PERIPH ? periph_req[g] &
                                                       ~pend[g] :
                 cfg[g].trig == mdc_pkg::TRIG_EXT    ? ext_rise[g]
                                                     : 1'b0);
            assign periph_ack[g] = trig_hit[g] &
                                   (cfg[g].trig == mdc_pkg::TRIG_PERIPH);
        end
    endgenerate

    // ****************************************************************
    // Arbitration and unit bookkeeping
    // ****************************************************************
    logic              arb_any, space_ok, grant, is_norm, is_rpt, is_blk;
    logic              size_last, cnt_dec, end_now, esc_now, elc_now;
    logic              keep_pend, src_wrap, dst_wrap, upd;
    logic [2:0]        arb_idx;
    logic [7:0]        cur_oh, upd_oh, bad_oh;
    logic [31:0]       step_src, step_dst, nx_src, nx_dst;
    logic [10:0]       nx_size_left;
    logic [15:0]       nx_bcnt;
    mdc_pkg::mdc_cfg_t cc;

    mdc_prio_arb u_arb (
        .req (pend & en_vec),
        .any (arb_any),
        .idx (arb_idx)
    );

    assign space_ok = mdc_pkg::in_space(src[arb_idx]) &&
                      mdc_pkg::in_space(dst[arb_idx]);
    assign grant    = (st == mdc_pkg::ST_IDLE) & arb_any & ~module_stop;
    assign bad_oh   = (grant & ~space_ok) ? (8'h1 << arb_idx) : 8'h0;

    assign cc        = cfg[cur_ch];
    assign upd       = (st == mdc_pkg::ST_UPDATE);
    assign cur_oh    = 8'h1 << cur_ch;
    assign upd_oh    = upd ? cur_oh : 8'h0;
    assign is_rpt    = (cc.mode == mdc_pkg::MODE_REPEAT);
    assign is_blk    = (cc.mode == mdc_pkg::MODE_BLOCK);
    assign is_norm   = ~is_rpt & ~is_blk;
    assign size_last = (size_left[cur_ch] == 11'd1);
    assign cnt_dec   = is_norm ? ~cc.free_run : size_last;
    assign end_now   = cnt_dec && (bcnt[cur_ch] == 16'd1);
    assign nx_bcnt   = cnt_dec ? bcnt[cur_ch] - 16'd1 : bcnt[cur_ch];
    assign nx_size_left = is_norm   ? size_left[cur_ch] :
                          size_last ? mdc_pkg::size_full(size_reg[cur_ch])
                                    : size_left[cur_ch] - 11'd1;
    assign esc_now   = (is_rpt & size_last) | src_wrap | dst_wrap;
    assign elc_now   = ~is_blk | size_last;
    assign keep_pend = is_blk & ~size_last;
    assign nx_src    = (is_rpt & size_last & ~cc.rpt_dst) ?
                       src_start[cur_ch] : step_src;
    assign nx_dst    = (is_rpt & size_last & cc.rpt_dst) ?
                       dst_start[cur_ch] : step_dst;

    mdc_addr_step u_src_step (
        .addr      (src[cur_ch]),
        .inc       (cc.src_inc),
        .usize     (cc.usize),
        .area_en   (cc.src_area_en),
        .area_bits (cc.src_area_bits),
        .next_addr (step_src),
        .wrapped   (src_wrap)
    );

    mdc_addr_step u_dst_step (
        .addr      (dst[cur_ch]),
        .inc       (cc.dst_inc),
        .usize     (cc.usize),
        .area_en   (cc.dst_area_en),
        .area_bits (cc.dst_area_bits),
        .next_addr (step_dst),
        .wrapped   (dst_wrap)
    );

    // ****************************************************************
    // Flags: a set in the same cycle as a clear wins
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tend <= 8'h0;
            esc  <= 8'h0;
            err  <= 8'h0;
            pend <= 8'h0;
        end else begin
            tend <= (upd_oh & {8{end_now}}) |
                    (tend & ~(stat_oh & {8{pwdata[0]}}));
            esc  <= (upd_oh & {8{esc_now}}) |
                    (esc & ~(stat_oh & {8{pwdata[1]}}));
            err  <= bad_oh | (err & ~(stat_oh & {8{pwdata[2]}}));
            pend <= trig_hit | (pend & en_vec & ~bad_oh &
                    ~(upd_oh & {8{~keep_pend}}));
        end
    end

    // ****************************************************************
    // Per-channel registers
    // ****************************************************************
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic wr_here, upd_here;
            assign wr_here  = wr_sel & a_oh[g];
            assign upd_here = upd_oh[g];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src[g]       <= 32'h0;
                    src_start[g] <= 32'h0;
                end else if (wr_here && a_off == mdc_pkg::OFF_SRC) begin
                    src[g]       <= pwdata;
                    src_start[g] <= pwdata;
                end else if (upd_here) begin
                    src[g]       <= nx_src;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dst[g]       <= 32'h0;
                    dst_start[g] <= 32'h0;
                end else if (wr_here && a_off == mdc_pkg::OFF_DST) begin
                    dst[g]       <= pwdata;
                    dst_start[g] <= pwdata;
                end else if (upd_here) begin
                    dst[g]       <= nx_dst;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    size_reg[g]  <= 10'h0;
                    size_left[g] <= mdc_pkg::SIZE_MAX;
                end else if (wr_here && a_off == mdc_pkg::OFF_SIZE) begin
                    size_reg[g]  <= pwdata[9:0];
                    size_left[g] <= mdc_pkg::size_full(pwdata[9:0]);
                end else if (upd_here) begin
                    size_left[g] <= nx_size_left;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bcnt[g] <= 16'h0;
                end else if (wr_here && a_off == mdc_pkg::OFF_BCNT) begin
                    bcnt[g] <= pwdata[15:0];
                end else if (upd_here) begin
                    bcnt[g] <= nx_bcnt;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg[g] <= '0;
                end else if (wr_here && a_off == mdc_pkg::OFF_CFG) begin
                    cfg[g] <= mdc_pkg::mdc_cfg_t'(pwdata[mdc_pkg::CFG_W-1:0]);
                end else if ((upd_here && end_now) || bad_oh[g]) begin
                    cfg[g].enable <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Engine: one unit per grant, read then write
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st       <= mdc_pkg::ST_IDLE;
            cur_ch   <= 3'h0;
            data_reg <= 32'h0;
        end else begin
            unique case (st)
                mdc_pkg::ST_IDLE: begin
                    if (grant) begin
                        cur_ch <= arb_idx;
                        if (space_ok) begin
                            st <= mdc_pkg::ST_READ;
                        end
                    end
                end
                mdc_pkg::ST_READ: begin
                    if (bm_ack) begin
                        data_reg <= bm_rdata;
                        st       <= mdc_pkg::ST_WRITE;
                    end
                end
                mdc_pkg::ST_WRITE: begin
                    if (bm_ack) begin
                        st <= mdc_pkg::ST_UPDATE;
                    end
                end
                mdc_pkg::ST_UPDATE: begin
                    st <= mdc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign bm_out.req   = (st == mdc_pkg::ST_READ) |
                          (st == mdc_pkg::ST_WRITE);
    assign bm_out.we    = (st == mdc_pkg::ST_WRITE);
    assign bm_out.size  = cc.usize;
    assign bm_out.addr  = bm_out.we ? dst[cur_ch] : src[cur_ch];
    assign bm_out.wdata = data_reg;

    assign elc_req  = upd & elc_now;
    assign elc_ch   = cur_ch;
    assign tend_irq = tend;
    assign esc_irq  = esc;
endmodule

// [hw/mdc_pkg.sv]
// Shared constants, types and helpers of the eight-channel DMA engine.
// Assumes an APB slave port at 32-bit data and a simple on-chip bus master.
package mdc_pkg;

    // ********
    // Sizes
    // ********
    localparam int          NCH        = 8;
    localparam int          CFG_W      = 23;
    localparam logic [10:0] SIZE_MAX   = 11'd1024;
    localparam logic [4:0]  AREA_MAX   = 5'd26;

    // ********
    // Register map (byte addresses)
    // ********
    localparam logic [4:0]  OFF_SRC    = 5'h00;
    localparam logic [4:0]  OFF_DST    = 5'h04;
    localparam logic [4:0]  OFF_SIZE   = 5'h08;
    localparam logic [4:0]  OFF_BCNT   = 5'h0c;
    localparam logic [4:0]  OFF_CFG    = 5'h10;
    localparam logic [4:0]  OFF_STAT   = 5'h14;
    localparam logic [8:0]  OFF_CTRL   = 9'h100;
    localparam logic [8:0]  OFF_SWTRIG = 9'h104;
    localparam logic [8:0]  OFF_MON    = 9'h108;
    localparam logic        RST_STOP   = 1'b0;

    // ********
    // Field encodings
    // ********
    localparam logic [1:0]  MODE_NORMAL = 2'h0;
    localparam logic [1:0]  MODE_REPEAT = 2'h1;
    localparam logic [1:0]  MODE_BLOCK  = 2'h2;
    localparam logic [1:0]  TRIG_SW     = 2'h0;
    localparam logic [1:0]  TRIG_PERIPH = 2'h1;
    localparam logic [1:0]  TRIG_EXT    = 2'h2;
    localparam logic [3:0]  SPACE_LO    = 4'h0;
    localparam logic [3:0]  SPACE_HI    = 4'hf;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_READ   = 2'b01,
        ST_WRITE  = 2'b11,
        ST_UPDATE = 2'b10
    } mdc_state_t;

    typedef struct packed {
        logic [4:0] dst_area_bits;
        logic [4:0] src_area_bits;
        logic       dst_area_en;
        logic       src_area_en;
        logic       rpt_dst;
        logic       dst_inc;
        logic       src_inc;
        logic [1:0] trig;
        logic [1:0] usize;
        logic       free_run;
        logic [1:0] mode;
        logic       enable;
    } mdc_cfg_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mdc_bus_req_t;

    // Block or repeat size: zero stands for the largest size
    function automatic logic [10:0] size_full(input logic [9:0] v);
        size_full = (v == 10'h0) ? SIZE_MAX : {1'b0, v};
    endfunction

    // Lowest or highest 256 MB of the map
    function automatic logic in_space(input logic [31:0] a);
        in_space = (a[31:28] == SPACE_LO) || (a[31:28] == SPACE_HI);
    endfunction

endpackage

// [hw/mdc_prio_arb.sv]
// Fixed-priority pick among channel requests, channel zero highest.
// Purely combinational; the caller registers the chosen index.
`timescale 1ns/1ps
module mdc_prio_arb (
    // Requests
    input  wire logic [7:0] req,
    // Choice
    output logic            any,
    output logic [2:0]      idx
);
    logic [7:0] oh;

    genvar i;
    generate
        for (i = 0; i < mdc_pkg::NCH; i++) begin : g_pick
            assign oh[i] = req[i] & ~|(req & ((8'h1 << i) - 8'h1));
        end
    endgenerate

    assign any = |req;

    always_comb begin
        idx = 3'h0;
        for (int k = 0; k < mdc_pkg::NCH; k++) begin
            if (oh[k]) begin
                idx = 3'(k);
            end
        end
    end
endmodule

// [verification/mdc_bus_model.sv]
// Bus slave model: word memory with a set wait per access.
// Assumes the engine holds its request until acknowledged.
`timescale 1ns/1ps
module mdc_bus_model (
    // Clock, reset and pacing
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [1:0]            wait_cyc,
    // Engine side
    input  wire mdc_pkg::mdc_bus_req_t bm_out,
    output logic                       bm_ack,
    output logic      [31:0]           bm_rdata
);
    logic [31:0] mem [64];
    logic [1:0]  cnt;
    logic [31:0] junk;
    wire  [5:0]  idx = bm_out.addr[7:2];
    assign bm_ack = bm_out.req && (cnt == wait_cyc);
    // Noise on the data lines outside an answer
    assign bm_rdata = bm_ack ? mem[idx] : junk;
    initial for (int i = 0; i < 64; i++) mem[i] = 32'hc0de_0000 + 32'(i);
    always @(posedge pclk) if (bm_ack && bm_out.we) mem[idx] <= bm_out.wdata;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 2'h0;
            junk <= 32'h0;
        end else begin
            junk <= junk + 32'h9e37_79b9;
            cnt  <= bm_ack ? 2'h0 : cnt + {1'b0, bm_out.req};
        end
    end
endmodule

// [verification/mdc_dma_properties.sv]
// Port checks of the eight-channel DMA engine.
// Assumes it is bound onto mdc_dma_top, one clock domain.
`timescale 1ns/1ps
module mdc_dma_properties (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic                  pslverr,
    // Triggers and bus master
    input wire logic [7:0]            periph_req,
    input wire logic [7:0]            periph_ack,
    input wire mdc_pkg::mdc_bus_req_t bm_out,
    input wire logic                  bm_ack,
    // Events
    input wire logic [7:0]            tend_irq,
    input wire logic                  elc_req
);
    // ********
    // Properties
    // ********
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_space;
        bm_out.req |-> bm_out.addr[31:28] inside {4'h0, 4'hf};
    endproperty
    a_space: assert property (p_space) else $error("bad address");
    property p_width; bm_out.req |-> bm_out.size != 2'h3; endproperty
    a_width: assert property (p_width) else $error("bad unit width");
    property p_hold;
        bm_out.req && !bm_ack |=> bm_out.req && $stable(bm_out.addr);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_elc_gap; elc_req |=> !elc_req [*3]; endproperty
    a_elc_gap: assert property (p_elc_gap) else $error("event too soon");
    property p_elc_cause;
        elc_req |-> $past(bm_ack && bm_out.req && bm_out.we);
    endproperty
    a_elc_cause: assert property (p_elc_cause) else $error("no write");
    property p_ack_cause; (periph_ack & ~periph_req) == 8'h0; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_ack_pulse;
        |periph_ack |=> (periph_ack & $past(periph_ack)) == 8'h0;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_tend_sticky;
        |($past(tend_irq) & ~tend_irq) |-> $past(psel && penable && pwrite);
    endproperty
    a_tend_sticky: assert property (p_tend_sticky) else $error("lost");
    c_elc: cover property (elc_req);
    c_ack: cover property (|periph_ack);
    c_err: cover property (pslverr);
endmodule
bind mdc_dma_top mdc_dma_properties chk_i (.*);

// [verification/tb_mdc_dma_top.sv]
// Self-checking bench of the eight-channel DMA engine.
// Assumes the bus model and the bound checker compile alongside.
`timescale 1ns/1ps
module tb_mdc_dma_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, serr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, bm_rdata;
    logic        pready, pslverr, bm_ack, elc_req;
    logic [7:0]  periph_req = 8'h0, ext_irq_pin = 8'h0;
    logic [7:0]  periph_ack, tend_irq, esc_irq;
    logic [2:0]  elc_ch;
    logic [1:0]  wait_cyc = 2'h0;
    int          err_count = 0, total_checks = 0, elc_n = 0;
    logic [2:0]  elc_log [$];
    mdc_pkg::mdc_bus_req_t bm_out;
    mdc_dma_top dut (.*);
    mdc_bus_model bus (.*);
    // ********
    // Clock, monitor and tasks
    // ********
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        if (elc_req === 1'b1) begin
            elc_n++;
            elc_log.push_back(elc_ch);
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setup(input logic [2:0] ch,
                         input logic [31:0] s, t, z, n, c);
        apb(1'b1, {24'h0, ch, mdc_pkg::OFF_SRC}, s);
        apb(1'b1, {24'h0, ch, mdc_pkg::OFF_DST}, t);
        apb(1'b1, {24'h0, ch, mdc_pkg::OFF_SIZE}, z);
        apb(1'b1, {24'h0, ch, mdc_pkg::OFF_BCNT}, n);
        apb(1'b1, {24'h0, ch, mdc_pkg::OFF_CFG}, c);
    endtask
    task automatic wait_elc(input int n);
        for (int i = 0; i < 400 && elc_n < n; i++) @(posedge pclk);
        repeat (12) @(posedge pclk);
        chk(32'(elc_n), 32'(n));
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        wrap_up();
    end
    // ********
    // Tests
    // ********
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 32'h10, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 32'hac, 32'hdead_beef);
        apb(1'b0, 32'hac, 32'h0);
        chk(rd, 32'h0000_beef);
        apb(1'b0, 32'h10c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, serr}, 32'h1);
        $display("test 1 done");
        setup(3'h1, 32'h0, 32'h80, 32'h1, 32'h2, 32'h321);
        apb(1'b1, 32'h104, 32'h2);
        wait_elc(1);
        chk(bus.mem[32], 32'hc0de_0000);
        apb(1'b1, 32'h104, 32'h2);
        wait_elc(2);
        chk(bus.mem[33], 32'hc0de_0001);
        apb(1'b0, 32'h34, 32'h0);
        chk(rd & 32'h1, 32'h1);
        $display("test 2 done");
        setup(3'h3, 32'h10, 32'ha0, 32'h1, 32'h1, 32'h321);
        setup(3'h7, 32'h14, 32'ha4, 32'h1, 32'h1, 32'h321);
        apb(1'b1, 32'h104, 32'h88);
        wait_elc(4);
        chk({29'h0, elc_log[2]}, 32'h3);
        chk({29'h0, elc_log[3]}, 32'h7);
        chk(bus.mem[41], 32'hc0de_0005);
        apb(1'b0, 32'h108, 32'h0);
        chk(rd, 32'h8);
        $display("test 3 done");
        wait_cyc <= 2'h2;
        setup(3'h0, 32'h20, 32'hc0, 32'h4, 32'h1, 32'h365);
        periph_req[0] <= 1'b1;
        for (int i = 0; i < 50 && periph_ack[0] !== 1'b1; i++) @(negedge pclk);
        @(posedge pclk);
        periph_req[0] <= 1'b0;
        wait_elc(5);
        chk(bus.mem[51], 32'hc0de_000b);
        apb(1'b0, 32'h14, 32'h0);
        chk(rd & 32'h1, 32'h1);
        $display("test 4 done");
        apb(1'b1, 32'h100, 32'h1);
        setup(3'h2, 32'h30, 32'he0, 32'h1, 32'h1, 32'h321);
        apb(1'b1, 32'h104, 32'h4);
        wait_elc(5);
        apb(1'b1, 32'h100, 32'h0);
        apb(1'b1, 32'h50, 32'h3a1);
        ext_irq_pin[2] <= 1'b1;
        wait_elc(6);
        chk(bus.mem[56], 32'hc0de_000c);
        setup(3'h4, 32'h40, 32'h60, 32'h2, 32'h1, 32'h81323);
        repeat (2) begin
            apb(1'b1, 32'h104, 32'h10);
            wait_elc(elc_n + 1);
        end
        apb(1'b0, 32'h80, 32'h0);
        chk(rd, 32'h40);
        apb(1'b0, 32'h84, 32'h0);
        chk(rd, 32'h60);
        apb(1'b1, 32'h94, 32'h1);
        apb(1'b0, 32'h108, 32'h0);
        chk(rd, 32'h18);
        chk({16'h0, tend_irq, esc_irq}, 32'h8f10);
        $display("test 5 done");
        wrap_up();
    end
endmodule
